// *** logic/otl_limit_logic.sv ***
// overtravel limit logic with wishbone register file
//
// What this block does
// RULE1 - direction mode zero: counterclockwise is forward, guarded by the forward limit.
// RULE2 - direction mode one: clockwise is forward, guarded by the forward limit.
// RULE3 - forward limit low allows forward motion; high prohibits it, forward overtravel.
// RULE4 - reverse limit low allows reverse motion; high prohibits it, reverse overtravel.
// RULE5 - motion opposite to the overtravel direction stays allowed.
// RULE6 - position error pulses are kept after an overtravel stop until clear input.
// RULE7 - forward disable digit one ignores the forward limit; zero uses it.
// RULE8 - reverse disable digit one ignores the reverse limit; zero uses it.
// RULE9 - limit behaviour applies in speed, position and torque control alike.
// RULE10 - limit enable digits take effect only at the next power-up.
// RULE11 - vertical axes should use stop method five, zero clamp after stopping.
// RULE12 - a setting can swap which connector input feeds forward and reverse limits.
// RULE13 - overtravel stops by brake, coast or plug braking, then coast or zero clamp.
// RULE14 - plug braking torque limit is a percentage, 0 to 300, default 300.
// RULE15 - both limit inputs are synchronised before use.
`timescale 1ns/100ps
`include "otl_map.svh"

module otl_limit_logic
	import otl_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// limit switches, connector positions a and b
	input  wire logic        limitInA,
	input  wire logic        limitInB,
	// supply restore strobe, latches pending settings
	input  wire logic        supplyRestore,
	// control mode, informational only
	input  wire logic [1:0]  ctrlMode,
	// motor motion and reference direction
	input  wire logic        motorCcw,
	input  wire logic        motorCw,
	input  wire logic        refCcw,
	input  wire logic        refCw,
	// position error pulses
	input  wire logic        cmdStep,
	input  wire logic        cmdFwd,
	input  wire logic        fbStep,
	input  wire logic        fbFwd,
	input  wire logic        errorCounterClear,
	// motion permission and stop drive
	output logic             allowCcw,
	output logic             allowCw,
	output otl_stop_t        stopCtrl,
	output logic      [8:0]  plugTorqueLimit,
	output logic             fwdOvertravel,
	output logic             revOvertravel,
	output logic      [15:0] posError,
	// interrupt
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////////
	// helper functions

	function automatic logic [31:0] selMask(input logic [3:0] sel);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++)
			m[b*8 +: 8] = {8{sel[b]}};
		return m;
	endfunction

	// stop kind on overtravel; unknown codes fall back to dynamic brake
	function automatic otl_state_t stopKind(input logic [3:0] sel);
		case (sel)
			4'h1:                      stopKind = ST_STOP_COAST;
			4'h2, 4'h3, 4'h4, 4'h5:    stopKind = ST_STOP_PLUG;
			default:                   stopKind = ST_STOP_DB;
		endcase
	endfunction

	function automatic logic clampAfter(input logic [3:0] sel);
		clampAfter = (sel == 4'h4) || (sel == 4'h5);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers

	logic [3:0]        funcSel_r;
	logic              dirSel_r;
	logic [3:0]        stopSel_r;
	logic [8:0]        plugTrq_r;
	otl_cfg_t          active_r;
	logic [`OTL_IRQ_W-1:0] irqSts_r;
	logic [`OTL_IRQ_W-1:0] irqEn_r;
	logic [`OTL_IRQ_W-1:0] irqEvt;
	logic [`OTL_IRQ_W-1:0] irqClr;
	logic [31:0]       wrMask;
	logic [31:0]       wrData;
	logic              wrStrobe;
	logic [31:0]       rdMux;
	otl_state_t        state_r;
	otl_state_t        state_nxt;
	logic [1:0]        limitSync;
	logic              fwdLimit;
	logic              revLimit;
	logic              fwdProhibit;
	logic              revProhibit;
	logic              movFwd;
	logic              movRev;
	logic              refFwdReq;
	logic              refRevReq;
	logic              fwdProhibitPrev_r;
	logic              revProhibitPrev_r;
	logic              stopDone;
	logic [9:0]        plugWr;

	assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign wrMask   = selMask(wb_sel_i);
	assign wrData   = wb_dat_i & wrMask;
	assign plugWr   = {1'b0, wrData[8:0]};

	////////////////////////////////////////////////////////////////////////////////
	// wishbone handshake: one wait state, write lands at the acked edge

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
			wb_dat_o <= rdMux;
	end

	always_comb
	begin
		rdMux = 32'h0000_0000;
		case (wb_adr_i)
			`OTL_REG_FUNC_SEL: rdMux = {28'h000_0000, funcSel_r};
			`OTL_REG_DIR_SEL:  rdMux = {31'h0000_0000, dirSel_r};
			`OTL_REG_STOP_SEL: rdMux = {28'h000_0000, stopSel_r};
			`OTL_REG_PLUG_TRQ: rdMux = {23'h00_0000, plugTrq_r};
			`OTL_REG_ACTIVE:   rdMux = {24'h00_0000, active_r};
			`OTL_REG_LIVE:     rdMux = {20'h0_0000, ctrlMode, state_r, limitSync, 3'b000,
				revProhibit, fwdProhibit};
			`OTL_REG_IRQ_STS:  rdMux = {29'h0000_0000, irqSts_r};
			`OTL_REG_IRQ_EN:   rdMux = {29'h0000_0000, irqEn_r};
			`OTL_REG_POS_ERR:  rdMux = {16'h0000, posError};
			default:           rdMux = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// pending settings, writable at any time

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			funcSel_r <= `OTL_FUNC_RST;
			dirSel_r  <= `OTL_DIR_RST;
			stopSel_r <= `OTL_STOP_RST;
		end
		else if (wrStrobe)
		begin
			if (wb_adr_i == `OTL_REG_FUNC_SEL)
				funcSel_r <= (funcSel_r & ~wrMask[3:0]) | wrData[3:0];
			if (wb_adr_i == `OTL_REG_DIR_SEL && wb_sel_i[0])
				dirSel_r <= wrData[`OTL_DIR_REV];
			if (wb_adr_i == `OTL_REG_STOP_SEL)
				stopSel_r <= (stopSel_r & ~wrMask[3:0]) | wrData[3:0];
		end
	end

	// torque limit acts at once; 9-bit values above full range saturate, higher bus bits are dropped
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			plugTrq_r <= `OTL_PLUG_RST;
		else if (wrStrobe && wb_adr_i == `OTL_REG_PLUG_TRQ && wb_sel_i[1:0] == 2'b11)
			plugTrq_r <= (plugWr > {1'b0, `OTL_PLUG_MAX}) ? `OTL_PLUG_MAX
				: wrData[8:0]; // RULE14
	end

	// settings take hold only on supply restore, whether or not the motor is moving
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			active_r <= '0;
		else if (supplyRestore)
			active_r <= {funcSel_r[`OTL_FUNC_SWAP], funcSel_r[`OTL_FUNC_REV_DIS],
				funcSel_r[`OTL_FUNC_FWD_DIS], dirSel_r, stopSel_r}; // RULE10
	end

	////////////////////////////////////////////////////////////////////////////////
	// limit inputs and permission

	otl_sync #(
		.WIDTH(`OTL_SYNC_STAGES)
	) u_sync (
		.clk     (clk),
		.rst     (rst),
		.asyncIn ({limitInB, limitInA}),
		.syncOut (limitSync)
	); // RULE15

	assign fwdLimit    = active_r.swapInputs ? limitSync[1] : limitSync[0]; // RULE12
	assign revLimit    = active_r.swapInputs ? limitSync[0] : limitSync[1]; // RULE12
	// no mode gating here: same limit action in every control mode
	assign fwdProhibit = fwdLimit && !active_r.fwdDisable; // RULE3 RULE7 RULE9
	assign revProhibit = revLimit && !active_r.revDisable; // RULE4 RULE8 RULE9

	assign movFwd    = active_r.dirReverse ? motorCw : motorCcw; // RULE1 RULE2
	assign movRev    = active_r.dirReverse ? motorCcw : motorCw; // RULE1 RULE2
	assign refFwdReq = active_r.dirReverse ? refCw : refCcw;
	assign refRevReq = active_r.dirReverse ? refCcw : refCw;

	// each direction is gated only by its own limit
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			allowCcw <= 1'b0;
			allowCw  <= 1'b0;
		end
		else
		begin
			allowCcw <= active_r.dirReverse ? !revProhibit : !fwdProhibit; // RULE1 RULE5
			allowCw  <= active_r.dirReverse ? !fwdProhibit : !revProhibit; // RULE2 RULE5
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fwdOvertravel <= 1'b1;
			revOvertravel <= 1'b1;
		end
		else
		begin
			fwdOvertravel <= fwdProhibit; // RULE3
			revOvertravel <= revProhibit; // RULE4
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// stop sequence

	assign stopDone = !motorCcw && !motorCw;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN:
				if ((fwdProhibit && movFwd) || (revProhibit && movRev))
					state_nxt = stopKind(active_r.stopSel); // RULE13
			ST_STOP_DB, ST_STOP_COAST, ST_STOP_PLUG:
				if (stopDone)
					state_nxt = clampAfter(active_r.stopSel) ? ST_HOLD_CLAMP
						: ST_HOLD_COAST; // RULE13 RULE11
			ST_HOLD_COAST, ST_HOLD_CLAMP:
				// release on clear limits or a reference that points away
				if ((!fwdProhibit && !revProhibit) || (fwdProhibit && refRevReq && !refFwdReq)
					|| (revProhibit && refFwdReq && !refRevReq))
					state_nxt = ST_RUN; // RULE5
			default:
				state_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_r <= ST_RUN;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stopCtrl        <= '0;
			plugTorqueLimit <= `OTL_PLUG_RST;
		end
		else
		begin
			stopCtrl.dynBrakeOn  <= (state_nxt == ST_STOP_DB); // RULE13
			stopCtrl.coastOn     <= (state_nxt == ST_STOP_COAST) || (state_nxt == ST_HOLD_COAST);
			stopCtrl.plugBrakeOn <= (state_nxt == ST_STOP_PLUG); // RULE13
			stopCtrl.zeroClampOn <= (state_nxt == ST_HOLD_CLAMP);
			plugTorqueLimit      <= plugTrq_r; // RULE14
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// position error: never dropped by the stop, only by the clear input

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			posError <= 16'h0000;
		else if (errorCounterClear)
			posError <= 16'h0000; // RULE6
		else
			posError <= posError
				+ ((cmdStep && cmdFwd) ? 16'h0001 : 16'h0000)
				- ((cmdStep && !cmdFwd) ? 16'h0001 : 16'h0000)
				- ((fbStep && fbFwd) ? 16'h0001 : 16'h0000)
				+ ((fbStep && !fbFwd) ? 16'h0001 : 16'h0000); // RULE6
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts: set wins over a clear in the same cycle

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fwdProhibitPrev_r <= 1'b1;
			revProhibitPrev_r <= 1'b1;
		end
		else
		begin
			fwdProhibitPrev_r <= fwdProhibit;
			revProhibitPrev_r <= revProhibit;
		end
	end

	assign irqEvt[`OTL_IRQ_FWD_OT]  = fwdProhibit && !fwdProhibitPrev_r;
	assign irqEvt[`OTL_IRQ_REV_OT]  = revProhibit && !revProhibitPrev_r;
	assign irqEvt[`OTL_IRQ_STOPPED] = (state_r == ST_STOP_DB || state_r == ST_STOP_COAST
		|| state_r == ST_STOP_PLUG) && stopDone;
	assign irqClr = (wrStrobe && wb_adr_i == `OTL_REG_IRQ_CLR) ? wrData[`OTL_IRQ_W-1:0]
		: '0;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irqSts_r <= '0;
		else
			irqSts_r <= (irqSts_r & ~irqClr) | irqEvt;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irqEn_r <= '0;
		else if (wrStrobe && wb_adr_i == `OTL_REG_IRQ_EN && wb_sel_i[0])
			irqEn_r <= wrData[`OTL_IRQ_W-1:0];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |((irqSts_r & ~irqClr | irqEvt) & irqEn_r);
	end

endmodule

// *** logic/otl_map.svh ***
// register offsets, field positions, reset values and timing counts of the limit logic
`ifndef OTL_MAP_SVH
`define OTL_MAP_SVH

`define OTL_ADDR_W        8
`define OTL_REG_FUNC_SEL  8'h00
`define OTL_REG_DIR_SEL   8'h04
`define OTL_REG_STOP_SEL  8'h08
`define OTL_REG_PLUG_TRQ  8'h0C
`define OTL_REG_ACTIVE    8'h10
`define OTL_REG_LIVE      8'h14
`define OTL_REG_IRQ_STS   8'h18
`define OTL_REG_IRQ_CLR   8'h1C
`define OTL_REG_IRQ_EN    8'h20
`define OTL_REG_POS_ERR   8'h24

`define OTL_FUNC_FWD_DIS  1
`define OTL_FUNC_REV_DIS  2
`define OTL_FUNC_SWAP     3
`define OTL_DIR_REV       0

`define OTL_FUNC_RST      4'h0
`define OTL_DIR_RST       1'b0
`define OTL_STOP_RST      4'h0
`define OTL_PLUG_RST      9'h12C
`define OTL_PLUG_MAX      9'h12C

`define OTL_IRQ_FWD_OT    0
`define OTL_IRQ_REV_OT    1
`define OTL_IRQ_STOPPED   2
`define OTL_IRQ_W         3

`define OTL_SYNC_STAGES   2

`endif

// *** logic/otl_pkg.sv ***
// types shared by the overtravel limit logic
package otl_pkg;

	typedef struct packed {
		logic       swapInputs;
		logic       revDisable;
		logic       fwdDisable;
		logic       dirReverse;
		logic [3:0] stopSel;
	} otl_cfg_t;

	typedef enum logic [2:0] {
		ST_RUN        = 3'b000,
		ST_STOP_DB    = 3'b001,
		ST_STOP_COAST = 3'b010,
		ST_STOP_PLUG  = 3'b011,
		ST_HOLD_COAST = 3'b100,
		ST_HOLD_CLAMP = 3'b101
	} otl_state_t;

	typedef struct packed {
		logic dynBrakeOn;
		logic coastOn;
		logic plugBrakeOn;
		logic zeroClampOn;
	} otl_stop_t;

endpackage

// *** logic/otl_sync.sv ***
// two-flop level synchroniser for the limit switch inputs
`timescale 1ns/100ps
`include "otl_map.svh"

module otl_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_r;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			// reset to high: a limit reads as prohibited until proven clear
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					stage1_r[i] <= 1'b1;
					syncOut[i]  <= 1'b1;
				end
				else
				begin
					stage1_r[i] <= asyncIn[i];
					syncOut[i]  <= stage1_r[i];
				end
			end
		end
	endgenerate

endmodule

// *** tb/otl_chk.sv ***
// port checker for the overtravel limit logic
`timescale 1ns/100ps
module otl_chk
	import otl_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// bus handshake
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	// limits and error pulses
	input wire logic        limitInA,
	input wire logic        limitInB,
	input wire logic        cmdStep,
	input wire logic        fbStep,
	input wire logic        errorCounterClear,
	// drive outputs
	input wire logic        allowCcw,
	input wire logic        allowCw,
	input wire otl_stop_t   stopCtrl,
	input wire logic [8:0]  plugTorqueLimit,
	input wire logic        fwdOvertravel,
	input wire logic        revOvertravel,
	input wire logic [15:0] posError
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_free;
		!limitInA && !limitInB;
	endsequence
	sequence s_idle;
		!errorCounterClear && !cmdStep && !fbStep;
	endsequence
	property p_ack_answer;
		s_req |=> wb_ack_o;
	endproperty
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	// three edges of sync and decode before the limits clear
	property p_free;
		s_free [*3] |=> !fwdOvertravel && !revOvertravel;
	endproperty
	property p_pair;
		$countones({allowCcw, allowCw}) == $countones({~fwdOvertravel, ~revOvertravel});
	endproperty
	property p_clear;
		errorCounterClear |=> posError == 16'h0000;
	endproperty
	property p_hold;
		s_idle |=> $stable(posError);
	endproperty
	property p_plug;
		plugTorqueLimit <= 9'h12C;
	endproperty
	property p_stop;
		$onehot0(stopCtrl);
	endproperty
	////////////////////////////////
	a_ack_answer: assert property (p_ack_answer)
		else $error("no ack after request");
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	a_free: assert property (p_free)
		else $error("overtravel with both limits clear");
	a_pair: assert property (p_pair)
		else $error("permission does not match overtravel");
	a_clear: assert property (p_clear)
		else $error("error count not cleared");
	a_hold: assert property (p_hold)
		else $error("error count moved without pulses");
	a_plug: assert property (p_plug)
		else $error("plug torque above limit");
	a_stop: assert property (p_stop)
		else $error("two stop drives at once");
endmodule
bind otl_limit_logic otl_chk chk_u (
	.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.limitInA(limitInA), .limitInB(limitInB), .cmdStep(cmdStep), .fbStep(fbStep),
	.errorCounterClear(errorCounterClear), .allowCcw(allowCcw), .allowCw(allowCw),
	.stopCtrl(stopCtrl), .plugTorqueLimit(plugTorqueLimit), .fwdOvertravel(fwdOvertravel),
	.revOvertravel(revOvertravel), .posError(posError)
);

// *** tb/otl_limit_logic_tb.sv ***
// self-checking bench for the overtravel limit logic
`timescale 1ns/100ps
`include "otl_map.svh"
module otl_limit_logic_tb;
	logic        clk, rst, cyc, stb, we, restore, clr, wCcw, wCw, hitA, hitB, ack;
	logic        cStep, cFwd, fStep, fFwd, aCcw, aCw, mCcw, mCw, rCcw, rCw;
	logic        limA, limB, fwdOt, revOt, irq;
	logic [1:0]  mode;
	logic [3:0]  sel, stop, v;
	logic [7:0]  adr;
	logic [8:0]  plug;
	logic [15:0] posErr, expErr;
	logic [31:0] dat, rdat;
	logic [63:0] q[$];
	int          n_fail, compares, seed, i, k, pv;
	otl_limit_logic dut_u (
		.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.limitInA(limA), .limitInB(limB), .supplyRestore(restore), .ctrlMode(mode),
		.motorCcw(mCcw), .motorCw(mCw), .refCcw(rCcw), .refCw(rCw), .cmdStep(cStep),
		.cmdFwd(cFwd), .fbStep(fStep), .fbFwd(fFwd), .errorCounterClear(clr),
		.allowCcw(aCcw), .allowCw(aCw), .stopCtrl(stop), .plugTorqueLimit(plug),
		.fwdOvertravel(fwdOt), .revOvertravel(revOt), .posError(posErr), .irq(irq)
	);
	otl_motion_model #(.COAST(4)) mdl_u (
		.clk(clk), .rst(rst), .wantCcw(wCcw), .wantCw(wCw), .hitA(hitA), .hitB(hitB),
		.allowCcw(aCcw), .allowCw(aCw), .motorCcw(mCcw), .motorCw(mCw), .refCcw(rCcw),
		.refCw(rCw), .limitInA(limA), .limitInB(limB)
	);
	////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1);
		chk(n, 2);
		{cyc, stb} <= 2'b00;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		q.push_back({m, e});
		wb(0, a, '0);
	endtask
	task apply();
		@(posedge clk);
		restore <= 1;
		@(posedge clk);
		restore <= 0;
	endtask
	// c is {swap, revDis, fwdDis, dirRev}; result {allowCcw, allowCw, fwdOt, revOt}
	function automatic logic [3:0] expOut(input logic [3:0] c, input logic a, input logic b);
		logic f, r;
		f = (c[3] ? b : a) & !c[1];
		r = (c[3] ? a : b) & !c[2];
		return {!(c[0] ? r : f), !(c[0] ? f : r), f, r};
	endfunction
	task tally_and_finish;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// read results land with ack; oldest note is the one due
	always @(posedge clk)
		if (ack === 1'b1 && !we)
		begin
			chk(rdat & q[0][63:32], q[0][31:0]);
			void'(q.pop_front());
		end
	initial
	begin
		#1_000_000;
		n_fail++;
		tally_and_finish;
	end
	initial
	begin
		{rst, cyc, stb, we, restore, clr, wCcw, wCw, hitA, hitB} = 10'h200;
		{cStep, cFwd, fStep, fFwd, mode, sel, adr, dat} = '0;
		{n_fail, compares, seed} = {32'd0, 32'd0, 32'd42251};
		repeat (8) @(posedge clk);
		rst <= 0;
		tick(4);
		chk({aCcw, aCw, fwdOt, revOt}, 4'b1100);
		chk(plug, 9'h12C);
		rd(`OTL_REG_ACTIVE, 32'h0000_00FF, '0);
		for (i = 0; i < 16; i++)
		begin
			wb(1, `OTL_REG_FUNC_SEL, 32'(i & 14));
			wb(1, `OTL_REG_DIR_SEL, 32'(i & 1));
			rd(`OTL_REG_ACTIVE, 32'h0000_00FF, i ? 32'((i - 1) << 4) : '0);
			apply();
			rd(`OTL_REG_ACTIVE, 32'h0000_00FF, 32'(i << 4));
			mode <= 2'(i % 3);
			for (k = 0; k < 4; k++)
			begin
				{hitB, hitA} <= 2'(k);
				tick(4);
				chk({aCcw, aCw, fwdOt, revOt}, expOut(4'(i), k[0], k[1]));
			end
			{hitB, hitA} <= 2'b00;
		end
		// every stop method, ending with zero clamp for a hanging load
		for (i = 0; i < 6; i++)
		begin
			wb(1, `OTL_REG_FUNC_SEL, '0);
			wb(1, `OTL_REG_DIR_SEL, '0);
			wb(1, `OTL_REG_STOP_SEL, 32'(i));
			apply();
			wCcw <= 1;
			tick(3);
			hitA <= 1;
			for (k = 0; k < 10 && stop === 4'h0; k++)
				@(posedge clk);
			chk(stop, i == 0 ? 4'b1000 : i == 1 ? 4'b0100 : 4'b0010);
			for (k = 0; k < 20 && mCcw; k++)
				@(posedge clk);
			tick(3);
			chk(stop, i >= 4 ? 4'b0001 : 4'b0100);
			{wCcw, hitA} <= 2'b00;
			tick(6);
			chk(stop, 4'h0);
		end
		rd(`OTL_REG_IRQ_STS, 32'h0000_0007, 32'h0000_0007);
		wb(1, `OTL_REG_IRQ_CLR, 32'h0000_0007);
		wb(1, `OTL_REG_IRQ_EN, 32'h0000_0001);
		tick(2);
		chk(irq, 1'b0);
		hitA <= 1;
		tick(5);
		chk(irq, 1'b1);
		rd(`OTL_REG_IRQ_STS, 32'h0000_0001, 32'h0000_0001);
		wb(1, `OTL_REG_IRQ_EN, '0);
		tick(2);
		chk(irq, 1'b0);
		wb(1, `OTL_REG_IRQ_EN, 32'h0000_0001);
		tick(2);
		chk(irq, 1'b1);
		wb(1, `OTL_REG_IRQ_CLR, 32'h0000_0001);
		tick(2);
		chk(irq, 1'b0);
		hitA <= 0;
		clr <= 1;
		tick(1);
		clr <= 0;
		expErr = '0;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk);
			v = 4'($random(seed));
			{cStep, cFwd, fStep, fFwd} <= v;
			expErr = expErr + (v[3] ? (v[2] ? 16'h0001 : 16'hFFFF) : 16'h0000);
			expErr = expErr + (v[1] ? (v[0] ? 16'hFFFF : 16'h0001) : 16'h0000);
		end
		@(posedge clk);
		{cStep, fStep} <= 2'b00;
		tick(4);
		chk(posErr, expErr);
		rd(`OTL_REG_POS_ERR, 32'h0000_FFFF, 32'(expErr));
		clr <= 1;
		tick(2);
		clr <= 0;
		chk(posErr, 16'h0000);
		pv = $unsigned($random(seed)) % 301;
		wb(1, `OTL_REG_PLUG_TRQ, 32'(pv));
		rd(`OTL_REG_PLUG_TRQ, 32'h0000_01FF, 32'(pv));
		chk(plug, 9'(pv));
		wb(1, `OTL_REG_PLUG_TRQ, 32'h0000_01FF);
		rd(`OTL_REG_PLUG_TRQ, 32'h0000_01FF, 32'h0000_012C);
		wb(1, `OTL_REG_ACTIVE, '1);
		rd(`OTL_REG_ACTIVE, 32'h0000_00FF, 32'h0000_0005);
		rd(8'h40, '1, '0);
		mode <= 2'b10;
		hitB <= 1;
		tick(4);
		rd(`OTL_REG_LIVE, 32'h0000_0FFF, 32'h0000_0842);
		tick(2);
		tally_and_finish;
	end
endmodule

// *** tb/otl_motion_model.sv ***
// limit switches and host controller around the drive
`timescale 1ns/100ps
module otl_motion_model #(
	parameter int COAST = 4
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// bench commands
	input  wire logic wantCcw,
	input  wire logic wantCw,
	input  wire logic hitA,
	input  wire logic hitB,
	// drive side
	input  wire logic allowCcw,
	input  wire logic allowCw,
	output logic      motorCcw,
	output logic      motorCw,
	output logic      refCcw,
	output logic      refCw,
	output logic      limitInA,
	output logic      limitInB
);
	logic [3:0] run_r;
	logic       ccw_r;
	// an opened switch reads high
	assign limitInA = hitA;
	assign limitInB = hitB;
	assign refCcw = wantCcw;
	assign refCw = wantCw;
	// the shaft runs on after permission goes, so a stop is seen
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			run_r <= 4'h0;
		else if ((wantCcw && allowCcw) || (wantCw && allowCw))
			run_r <= 4'(COAST);
		else if (run_r != 4'h0)
			run_r <= run_r - 4'h1;
	end
	always_ff @(posedge clk)
		if (wantCcw || wantCw)
			ccw_r <= wantCcw;
	assign motorCcw = run_r != 4'h0 && ccw_r;
	assign motorCw = run_r != 4'h0 && !ccw_r;
endmodule
